// file: hw/prox_map.svh
// Register map, field positions, reset values and timing counts of the
// pulsed proximity measurement core. Definitions only.
`ifndef PROX_MAP_SVH
`define PROX_MAP_SVH

// Command codes (register indices on the serial link)
`define REG_CONF 8'h03
`define REG_DRIVE 8'h04
`define REG_THR_HIGH 8'h05
`define REG_THR_LOW 8'h06
`define REG_CANCEL 8'h07
`define REG_RESULT 8'h08
`define REG_STATUS 8'h09

// Configuration word fields
`define CONF_SD_BIT 0
`define CONF_PERIOD_LSB 1
`define CONF_IT_LSB 3
`define CONF_ITB_LSB 5
`define CONF_PERS_LSB 7
`define CONF_INT_CLOSE_EN_BIT 9
`define CONF_INT_AWAY_EN_BIT 10
`define CONF_RESET 16'h0001

// Drive word fields
`define DRV_STEP_LSB 0
`define DRV_FORCED_BIT 3
`define DRV_TRIG_BIT 4
`define DRV_RESET 16'h0000
`define DRV_STEP_MAX 3'h4

// Status word fields
`define STAT_CLOSE_BIT 0
`define STAT_AWAY_BIT 1
`define STAT_NEAR_BIT 8

`define THR_HIGH_RESET 16'hFFFF
`define THR_LOW_RESET 16'h0000
`define CANCEL_RESET 16'h0000

// Serial address of the device (7 bits)
`define I2C_SLAVE_ADDR 7'h51

// Timing: system clock rate, base unit and shortest repetition interval
`define CLK_SYS_MHZ 200
`define BASE_UNIT_US 50
`define BASE_UNIT_CYC (`BASE_UNIT_US * `CLK_SYS_MHZ)
`define PERIOD_MIN_MS 8
`define PERIOD_MIN_CYC (`PERIOD_MIN_MS * 1000 * `CLK_SYS_MHZ)

`endif

// file: hw/prox_pkg.sv
// Types shared by the proximity core and its serial link slave.
// Assumes prox_map.svh supplies all numeric constants.
package prox_pkg;

  typedef enum logic [2:0] {
    MEAS_IDLE,
    MEAS_PULSE,
    MEAS_CONV
  } meas_state_t;

  typedef enum logic [3:0] {
    LNK_IDLE,
    LNK_ADDR,
    LNK_ADDR_ACK,
    LNK_CMD,
    LNK_CMD_ACK,
    LNK_WDATA,
    LNK_WDATA_ACK,
    LNK_RDATA,
    LNK_RDATA_ACK
  } link_state_t;

endpackage

// file: hw/i2c_link_slave.sv
// Serial two-wire bus slave on the link clock: 16-bit words, low byte
// first. Assumes a system-side register file answering toggle handshakes.
`timescale 1ns/1ps
`include "prox_map.svh"

module i2c_link_slave #(
  parameter logic [6:0] SLAVE_ADDR = `I2C_SLAVE_ADDR
) (
  input wire logic clk_link,
  input wire logic rstn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_oe_n,
  output logic wr_tgl,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data,
  output logic rd_tgl,
  output logic [7:0] rd_addr,
  input wire logic rd_ack_tgl,
  input wire logic [15:0] rd_data
);

  prox_pkg::link_state_t state_q;
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_p_q;
  logic sda_p_q;
  logic [1:0] ack_s_q;
  logic ack_p_q;
  logic [15:0] rd_word_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shreg_q;
  logic [7:0] tx_q;
  logic [7:0] lo_q;
  logic rw_q;
  logic hi_q;
  logic nack_q;
  logic drive_low_q;
  logic scl;
  logic sda;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;

  // Pins cross into this domain through two flip-flops
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_pin};
      sda_s_q <= {sda_s_q[0], sda_pin};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  assign scl = scl_s_q[1];
  assign sda = sda_s_q[1];
  assign start_c = scl && scl_p_q && sda_p_q && !sda;
  assign stop_c = scl && scl_p_q && !sda_p_q && sda;
  assign rise_c = scl && !scl_p_q;
  assign fall_c = !scl && scl_p_q;
  assign sda_oe_n = !drive_low_q;

  // Read answer: data is held stable by the system side before the toggle
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      ack_s_q <= 2'h0;
      ack_p_q <= 1'b0;
      rd_word_q <= 16'h0000;
    end else begin
      ack_s_q <= {ack_s_q[0], rd_ack_tgl};
      ack_p_q <= ack_s_q[1];
      if (ack_s_q[1] != ack_p_q) begin
        rd_word_q <= rd_data;
      end
    end
  end

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      state_q <= prox_pkg::LNK_IDLE;
      bit_cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      tx_q <= 8'h00;
      lo_q <= 8'h00;
      rw_q <= 1'b0;
      hi_q <= 1'b0;
      nack_q <= 1'b0;
      drive_low_q <= 1'b0;
      wr_tgl <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 16'h0000;
      rd_tgl <= 1'b0;
      rd_addr <= 8'h00;
    end else if (start_c) begin
      state_q <= prox_pkg::LNK_ADDR;
      bit_cnt_q <= 4'h0;
      hi_q <= 1'b0;
      drive_low_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= prox_pkg::LNK_IDLE;
      drive_low_q <= 1'b0;
    end else if (rise_c) begin
      if (state_q == prox_pkg::LNK_RDATA_ACK) begin
        nack_q <= sda;
      end else begin
        shreg_q <= {shreg_q[6:0], sda};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end else if (fall_c) begin
      case (state_q)
        prox_pkg::LNK_ADDR: begin
          if (bit_cnt_q == 4'h8) begin
            if (shreg_q[7:1] == SLAVE_ADDR) begin
              rw_q <= shreg_q[0];
              drive_low_q <= 1'b1;
              state_q <= prox_pkg::LNK_ADDR_ACK;
            end else begin
              state_q <= prox_pkg::LNK_IDLE;
            end
          end
        end
        prox_pkg::LNK_ADDR_ACK: begin
          bit_cnt_q <= 4'h0;
          if (rw_q) begin
            tx_q <= rd_word_q[7:0];
            drive_low_q <= !rd_word_q[7];
            state_q <= prox_pkg::LNK_RDATA;
          end else begin
            drive_low_q <= 1'b0;
            state_q <= prox_pkg::LNK_CMD;
          end
        end
        prox_pkg::LNK_CMD: begin
          if (bit_cnt_q == 4'h8) begin
            // Fetch early: the repeated start leaves many bit times
            rd_addr <= shreg_q;
            rd_tgl <= !rd_tgl;
            wr_addr <= shreg_q;
            drive_low_q <= 1'b1;
            state_q <= prox_pkg::LNK_CMD_ACK;
          end
        end
        prox_pkg::LNK_CMD_ACK, prox_pkg::LNK_WDATA_ACK: begin
          drive_low_q <= 1'b0;
          bit_cnt_q <= 4'h0;
          state_q <= prox_pkg::LNK_WDATA;
        end
        prox_pkg::LNK_WDATA: begin
          if (bit_cnt_q == 4'h8) begin
            if (hi_q) begin
              wr_data <= {shreg_q, lo_q};
              wr_tgl <= !wr_tgl;
            end else begin
              lo_q <= shreg_q;
            end
            hi_q <= !hi_q;
            drive_low_q <= 1'b1;
            state_q <= prox_pkg::LNK_WDATA_ACK;
          end
        end
        // Rises already count the bits; release after the eighth
        prox_pkg::LNK_RDATA: begin
          if (bit_cnt_q == 4'h8) begin
            drive_low_q <= 1'b0;
            state_q <= prox_pkg::LNK_RDATA_ACK;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            drive_low_q <= !tx_q[6];
          end
        end
        prox_pkg::LNK_RDATA_ACK: begin
          if (nack_q) begin
            state_q <= prox_pkg::LNK_IDLE;
          end else begin
            tx_q <= hi_q ? rd_word_q[7:0] : rd_word_q[15:8];
            drive_low_q <= hi_q ? !rd_word_q[7] : !rd_word_q[15];
            hi_q <= !hi_q;
            bit_cnt_q <= 4'h0;
            state_q <= prox_pkg::LNK_RDATA;
          end
        end
        default: begin
          drive_low_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: hw/prox_core.sv
// Pulsed proximity measurement core: emitter scheduling, offset removal,
// persistence filter, interrupt pin and register file behind the link.
// Assumes an on-chip converter on clk_sys and a link slave on clk_link.
//
// What this block does
// R01: Deliver each proximity result as an unsigned 12-bit value.
// R02: Drive current has five selectable steps, lowest to highest.
// R03: Repeat emitter pulse at a programmable interval, 8 ms to 64 ms.
// R04: Four selectable integration settings change proximity sensitivity.
// R05: Pulse length equals integration multiple times base unit, 1 to 8.
// R06: Base-unit setting sets duration of one unit, scaling all pulse lengths but not the repetition interval.
// R07: Host should program base unit to 50 us.
// R08: Host measures offset and writes it to cancellation register 7.
// R09: Reported result is raw count minus programmed cancellation value.
// R10: Interrupt only after programmed count of consecutive crossings.
// R11: Assert interrupt pin on programmed proximity change.
// R12: Host reads results and programs settings over serial bus slave.
// R13: Start in shutdown; measurements begin once shutdown bit cleared.
// R14: In forced mode, trigger bit runs exactly one measurement.
// R15: Persistence accepts one to four consecutive crossings.
// R16: Clamp offset-subtracted result at zero instead of wrapping.
// R17: Any non-crossing measurement restarts the consecutive count.
`timescale 1ns/1ps
`include "prox_map.svh"

module prox_core #(
  parameter int unsigned BASE_UNIT_CYC = `BASE_UNIT_CYC,
  parameter int unsigned PERIOD_MIN_CYC = `PERIOD_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_link,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe_n,
  output logic int_out,
  output logic int_oe_n,
  output logic emitter_on,
  output logic [2:0] drive_step,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [11:0] adc_count
);

  prox_pkg::meas_state_t meas_q;
  logic [15:0] conf_q;
  logic [15:0] drv_q;
  logic [15:0] thr_high_q;
  logic [15:0] thr_low_q;
  logic [15:0] cancel_q;
  logic [11:0] result_q;
  logic close_flag_q;
  logic away_flag_q;
  logic near_q;
  logic [2:0] hit_cnt_q;
  logic [31:0] period_cnt_q;
  logic [31:0] pulse_cnt_q;
  logic [15:0] rd_data_q;
  logic rd_ack_tgl_q;
  logic [1:0] wr_s_q;
  logic wr_p_q;
  logic [1:0] rd_s_q;
  logic rd_p_q;
  logic wr_tgl;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic rd_tgl;
  logic [7:0] rd_addr;
  logic wr_ev;
  logic rd_ev;
  logic shutdown;
  logic forced;
  logic periodic_run;
  logic period_tick;
  logic start_meas;
  logic meas_done;
  logic [11:0] net_count;
  logic hit;
  logic persist_met;
  logic stat_read;

  function automatic logic [11:0] sub_clamp(input logic [11:0] raw,
                                            input logic [15:0] canc);
    logic [16:0] diff;
    diff = {5'h00, raw} - {1'b0, canc};
    sub_clamp = diff[16] ? 12'h000 : diff[11:0];
  endfunction

  function automatic logic [31:0] pulse_cycles(input logic [1:0] itb,
                                               input logic [1:0] it);
    logic [31:0] unit;
    // Base unit choices: half, one, two and four times the nominal unit
    unit = (BASE_UNIT_CYC << itb) >> 1;
    if (unit == 32'h0) begin
      unit = 32'h1;
    end
    pulse_cycles = unit << it;
  endfunction

  function automatic logic [31:0] period_cycles(input logic [1:0] sel);
    period_cycles = PERIOD_MIN_CYC << sel;
  endfunction

  i2c_link_slave u_link (
    .clk_link(clk_link),
    .rstn(rstn),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .sda_oe_n(sda_oe_n),
    .wr_tgl(wr_tgl),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_tgl(rd_tgl),
    .rd_addr(rd_addr),
    .rd_ack_tgl(rd_ack_tgl_q),
    .rd_data(rd_data_q)
  ); // R12

  // Only ever pulls the line low
  assign sda_out = 1'b0;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_s_q <= 2'h0;
      wr_p_q <= 1'b0;
      rd_s_q <= 2'h0;
      rd_p_q <= 1'b0;
    end else begin
      wr_s_q <= {wr_s_q[0], wr_tgl};
      wr_p_q <= wr_s_q[1];
      rd_s_q <= {rd_s_q[0], rd_tgl};
      rd_p_q <= rd_s_q[1];
    end
  end

  assign wr_ev = wr_s_q[1] != wr_p_q;
  assign rd_ev = rd_s_q[1] != rd_p_q;
  assign stat_read = rd_ev && (rd_addr == `REG_STATUS);

  assign shutdown = conf_q[`CONF_SD_BIT];
  assign forced = drv_q[`DRV_FORCED_BIT];
  assign periodic_run = !shutdown && !forced;
  assign period_tick = periodic_run && (period_cnt_q == 32'h0);
  assign start_meas = (meas_q == prox_pkg::MEAS_IDLE) && !shutdown &&
                      (period_tick || (forced && drv_q[`DRV_TRIG_BIT]));
  assign meas_done = (meas_q == prox_pkg::MEAS_CONV) && adc_done;
  assign net_count = sub_clamp(adc_count, cancel_q); // R09 R16
  assign hit = near_q ? ({4'h0, net_count} < thr_low_q) :
                        ({4'h0, net_count} > thr_high_q);
  assign persist_met =
    hit_cnt_q == conf_q[`CONF_PERS_LSB +: 2] + 2'h0; // R10 R15

  // Register writes; trigger self-clears once its measurement is done
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conf_q <= `CONF_RESET; // R13
      drv_q <= `DRV_RESET;
      thr_high_q <= `THR_HIGH_RESET;
      thr_low_q <= `THR_LOW_RESET;
      cancel_q <= `CANCEL_RESET;
    end else begin
      if (meas_done || shutdown || !forced) begin
        drv_q[`DRV_TRIG_BIT] <= 1'b0; // R14
      end
      if (wr_ev) begin
        case (wr_addr)
          `REG_CONF: conf_q <= wr_data;
          `REG_DRIVE: drv_q <= wr_data;
          `REG_THR_HIGH: thr_high_q <= wr_data;
          `REG_THR_LOW: thr_low_q <= wr_data;
          `REG_CANCEL: cancel_q <= wr_data; // R08
          default: begin
          end
        endcase
      end
    end
  end

  // Read answer held stable until the next request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 16'h0000;
      rd_ack_tgl_q <= 1'b0;
    end else if (rd_ev) begin
      rd_ack_tgl_q <= !rd_ack_tgl_q;
      case (rd_addr)
        `REG_CONF: rd_data_q <= conf_q;
        `REG_DRIVE: rd_data_q <= drv_q;
        `REG_THR_HIGH: rd_data_q <= thr_high_q;
        `REG_THR_LOW: rd_data_q <= thr_low_q;
        `REG_CANCEL: rd_data_q <= cancel_q;
        `REG_RESULT: rd_data_q <= {4'h0, result_q}; // R01
        `REG_STATUS: begin
          rd_data_q <= 16'h0000;
          rd_data_q[`STAT_CLOSE_BIT] <= close_flag_q;
          rd_data_q[`STAT_AWAY_BIT] <= away_flag_q;
          rd_data_q[`STAT_NEAR_BIT] <= near_q;
        end
        default: rd_data_q <= 16'h0000;
      endcase
    end
  end

  // Repetition interval runs only while periodic measuring is enabled
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_cnt_q <= 32'h0;
    end else if (!periodic_run) begin
      period_cnt_q <= 32'h0;
    end else if (period_cnt_q == 32'h0) begin
      period_cnt_q <= period_cycles(conf_q[`CONF_PERIOD_LSB +: 2]) -
                      32'h1; // R03
    end else begin
      period_cnt_q <= period_cnt_q - 32'h1;
    end
  end

  // Emitter pulse then conversion; shutdown aborts at once
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meas_q <= prox_pkg::MEAS_IDLE;
      pulse_cnt_q <= 32'h0;
      adc_start <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      case (meas_q)
        prox_pkg::MEAS_IDLE: begin
          if (start_meas) begin
            pulse_cnt_q <= pulse_cycles(conf_q[`CONF_ITB_LSB +: 2],
                                        conf_q[`CONF_IT_LSB +: 2]) -
                           32'h1; // R04 R05 R06
            meas_q <= prox_pkg::MEAS_PULSE;
          end
        end
        prox_pkg::MEAS_PULSE: begin
          if (shutdown) begin
            meas_q <= prox_pkg::MEAS_IDLE;
          end else if (pulse_cnt_q == 32'h0) begin
            adc_start <= 1'b1;
            meas_q <= prox_pkg::MEAS_CONV;
          end else begin
            pulse_cnt_q <= pulse_cnt_q - 32'h1;
          end
        end
        prox_pkg::MEAS_CONV: begin
          if (shutdown || adc_done) begin
            meas_q <= prox_pkg::MEAS_IDLE;
          end
        end
        default: meas_q <= prox_pkg::MEAS_IDLE;
      endcase
    end
  end

  assign emitter_on = (meas_q == prox_pkg::MEAS_PULSE);
  // Codes above the top step saturate at the top step
  assign drive_step = (drv_q[`DRV_STEP_LSB +: 3] > `DRV_STEP_MAX) ?
                      `DRV_STEP_MAX : drv_q[`DRV_STEP_LSB +: 3]; // R02

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      result_q <= 12'h000;
    end else if (meas_done) begin
      result_q <= net_count; // R01 R09
    end
  end

  // Persistence filter: run of crossings flips near/away state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hit_cnt_q <= 3'h0;
      near_q <= 1'b0;
    end else if (meas_done) begin
      if (!hit) begin
        hit_cnt_q <= 3'h0; // R17
      end else if (persist_met) begin
        hit_cnt_q <= 3'h0;
        near_q <= !near_q; // R10
      end else begin
        hit_cnt_q <= hit_cnt_q + 3'h1;
      end
    end
  end

  // Sticky event flags; reading status clears them but a new event wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      close_flag_q <= 1'b0;
      away_flag_q <= 1'b0;
    end else begin
      if (meas_done && hit && persist_met && !near_q &&
          conf_q[`CONF_INT_CLOSE_EN_BIT]) begin
        close_flag_q <= 1'b1; // R11
      end else if (stat_read) begin
        close_flag_q <= 1'b0;
      end
      if (meas_done && hit && persist_met && near_q &&
          conf_q[`CONF_INT_AWAY_EN_BIT]) begin
        away_flag_q <= 1'b1; // R11
      end else if (stat_read) begin
        away_flag_q <= 1'b0;
      end
    end
  end

  // Open-drain, active low on the wire
  assign int_out = 1'b0;
  assign int_oe_n = !(close_flag_q || away_flag_q); // R11

endmodule

// file: tb/prox_core_checker.sv
// Port-level timing checker for prox_core.
// Assumes it is bound into prox_core and sees only its ports.
`timescale 1ns/1ps
module prox_core_checker #(
  parameter int unsigned BASE_UNIT_CYC = 4,
  parameter int unsigned PERIOD_MIN_CYC = 200
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_link,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic int_out,
  input wire logic int_oe_n,
  input wire logic emitter_on,
  input wire logic [2:0] drive_step,
  input wire logic adc_start,
  input wire logic adc_done,
  input wire logic [11:0] adc_count
);
  sequence pulse_end_s;
    emitter_on ##1 !emitter_on;
  endsequence

  pulse_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    pulse_end_s |-> adc_start) else $error("no convert after pulse");
  start_once_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    adc_start |=> !adc_start) else $error("convert pulse too long");
  start_cause_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(adc_start) |-> $past(emitter_on)) else $error("convert w/o pulse");
  reset_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) |-> sda_oe_n && int_oe_n && !emitter_on && !adc_start)
    else $error("outputs busy after reset");
  step_range_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    drive_step <= 3'h4) else $error("drive step out of range");
  pin_value_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !sda_out && !int_out) else $error("open drain value not low");
  int_cause_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(int_oe_n) |-> $past(adc_done) || $past(adc_done, 2)
    || $past(adc_done, 3)) else $error("interrupt without measurement");
  sda_edge_a: assert property (@(posedge clk_link) disable iff (!rstn)
    $changed(sda_oe_n) |-> !scl_pin) else $error("data moved with clock high");
  ack_hold_a: assert property (@(posedge clk_link) disable iff (!rstn)
    $fell(sda_oe_n) |=> !sda_oe_n [*3]) else $error("data low too short");
endmodule

// file: tb/i2c_host_model.sv
// Host microcontroller model: two-wire bus master, open-drain outputs.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/1ps
`include "prox_map.svh"
module i2c_host_model (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl_low,
  output logic sda_low
);
  // Quarter bit of 125 cycles keeps the bus at 400 kHz
  localparam int QTR = 125;
  int nack_count = 0;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic qtr();
    repeat (QTR) @(negedge clk);
  endtask

  // Data only moves while the clock is held low
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    qtr();
    scl_low = 1'b0;
    qtr();
    r = sda_in;
    qtr();
    scl_low = 1'b1;
    qtr();
  endtask

  task automatic bus_start();
    sda_low = 1'b0;
    qtr();
    scl_low = 1'b0;
    qtr();
    sda_low = 1'b1;
    qtr();
    scl_low = 1'b1;
    qtr();
  endtask

  task automatic bus_stop();
    sda_low = 1'b1;
    qtr();
    scl_low = 1'b0;
    qtr();
    sda_low = 1'b0;
    qtr();
  endtask

  task automatic byte_out(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nack_count++;
  endtask

  task automatic byte_in(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~ack, r);
  endtask

  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d);
    bus_start();
    byte_out({`I2C_SLAVE_ADDR, 1'b0});
    byte_out(cmd);
    byte_out(d[7:0]);
    byte_out(d[15:8]);
    bus_stop();
  endtask

  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
    logic [7:0] lo;
    logic [7:0] hi;
    bus_start();
    byte_out({`I2C_SLAVE_ADDR, 1'b0});
    byte_out(cmd);
    bus_start();
    byte_out({`I2C_SLAVE_ADDR, 1'b1});
    byte_in(1'b1, lo);
    byte_in(1'b0, hi);
    bus_stop();
    d = {hi, lo};
  endtask
endmodule

// file: tb/prox_core_bench.sv
// Top bench for prox_core: host model on the wires, converter stub.
// Assumes shortened unit and period parameters; run about 550 us.
`timescale 1ns/1ps
`include "prox_map.svh"
module prox_core_bench;
  localparam int unsigned UNIT = 4;
  localparam int unsigned PMIN = 200;
  logic clk_sys, clk_link, rstn;
  logic adc_done = 1'b0;
  logic [11:0] adc_count = 12'h000;
  logic scl_low, sda_low, sda_out, sda_oe_n, int_out, int_oe_n;
  logic emitter_on, adc_start;
  logic [2:0] drive_step;
  logic [15:0] rd;
  wire logic scl_pin = ~scl_low;
  wire logic sda_pin = ~sda_low & sda_oe_n;
  int fail_count = 0;
  int total_checks = 0;
  int meas_count = 0;
  int run_len = 0;
  int last_run = 0;

  prox_core #(.BASE_UNIT_CYC(UNIT), .PERIOD_MIN_CYC(PMIN)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link),
    .scl_pin(scl_pin), .sda_pin(sda_pin), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
    .emitter_on(emitter_on), .drive_step(drive_step),
    .adc_start(adc_start), .adc_done(adc_done), .adc_count(adc_count));
  i2c_host_model HOST (.clk(clk_sys), .sda_in(sda_pin),
    .scl_low(scl_low), .sda_low(sda_low));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7.3;
    forever #15 clk_link = ~clk_link;
  end

  // Second measurement misses so the hit run must restart; top drive
  // step marks the forced shot, whose low count must clamp to zero
  always @(negedge clk_sys) begin
    adc_done <= adc_start;
    if (adc_start) begin
      if (drive_step == 3'h4) begin
        adc_count <= 12'h008;
      end else begin
        adc_count <= (meas_count == 1) ? 12'h050 : 12'h200;
      end
      meas_count <= meas_count + 1;
    end
  end
  // Sampled on the falling edge, opposite the rising edge that moves the emitter
  always @(negedge clk_sys) begin
    if (emitter_on) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_run <= run_len;
      run_len <= 0;
    end
  end

  task automatic check_word(input logic [15:0] exp, input logic [15:0] act);
    total_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask
  task automatic check_bit(input logic exp, input logic act);
    check_word({15'h0000, exp}, {15'h0000, act});
  endtask
  task automatic wait_meas(input int n);
    int k;
    k = 0;
    while (meas_count < n && k < 20000) begin
      @(negedge clk_sys);
      k++;
    end
    check_bit(1'b1, k < 20000);
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic t_reset_idle();
    check_bit(1'b1, int_oe_n);
    check_word(16'h0000, {13'h0000, drive_step});
  endtask
  task automatic t_shutdown_setup();
    HOST.write_word(`REG_CANCEL, 16'h0010);
    HOST.write_word(`REG_THR_HIGH, 16'h0100);
    check_word(16'h0000, 16'(meas_count));
  endtask
  // 64 ms slot, 4T at 1x unit, two hits, close interrupt on
  task automatic t_periodic_persist();
    HOST.write_word(`REG_CONF, 16'h02B6);
    wait_meas(3);
    check_bit(1'b1, int_oe_n);
    check_word(16'(4 * UNIT), 16'(last_run));
    wait_meas(4);
    check_bit(1'b0, int_oe_n);
  endtask
  task automatic t_forced_single();
    int c;
    HOST.write_word(`REG_DRIVE, 16'h001C);
    c = meas_count;
    check_word(16'h0004, {13'h0000, drive_step});
    repeat (3 * 8 * PMIN) @(negedge clk_sys);
    check_word(16'(c), 16'(meas_count));
    HOST.read_word(`REG_RESULT, rd);
    check_word(16'h0000, rd);
    check_word(16'h0000, 16'(HOST.nack_count));
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (40) @(negedge clk_sys);
    t_reset_idle();
    t_shutdown_setup();
    t_periodic_persist();
    t_forced_single();
    report_and_stop();
  end
  initial begin
    #700000;
    fail_count++;
    report_and_stop();
  end
endmodule

bind prox_core prox_core_checker #(.BASE_UNIT_CYC(BASE_UNIT_CYC),
  .PERIOD_MIN_CYC(PERIOD_MIN_CYC)) u_checker (.clk_sys(clk_sys),
  .rstn(rstn), .clk_link(clk_link), .scl_pin(scl_pin), .sda_pin(sda_pin),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out),
  .int_oe_n(int_oe_n), .emitter_on(emitter_on), .drive_step(drive_step),
  .adc_start(adc_start), .adc_done(adc_done), .adc_count(adc_count));
